//--- src/irq_dma_route_map.vh
// Register indices, reset values, address limits and mode codes for the
// interrupt and DMA routing block of the multi-function I/O controller.
// Included by bare name from every design file that needs it.
`ifndef IRQ_DMA_ROUTE_MAP_VH
`define IRQ_DMA_ROUTE_MAP_VH

// ----------------------------------------------------------------------
// Configuration register indices
// ----------------------------------------------------------------------
`define IDX_LDN             8'h07
`define IDX_POWER           8'h22
`define IDX_GLOBAL_CFG      8'h24
`define IDX_CFG_BASE_LO     8'h26
`define IDX_CFG_BASE_HI     8'h27
`define IDX_ACTIVATE        8'h30
`define IDX_BASE_HI         8'h60
`define IDX_BASE_LO         8'h61
`define IDX_IRQ_SEL         8'h70
`define IDX_DMA_SEL         8'h74

// ----------------------------------------------------------------------
// Logical device numbers and power control bit positions
// ----------------------------------------------------------------------
`define LDN_FLOPPY          8'h00
`define LDN_PARALLEL        8'h03
`define LDN_SERIAL1         8'h04
`define LDN_SERIAL2         8'h05
`define PWR_BIT_FLOPPY      0
`define PWR_BIT_PARALLEL    3
`define PWR_BIT_SERIAL1     4
`define PWR_BIT_SERIAL2     5

// ----------------------------------------------------------------------
// Addresses, fields and reset values
// ----------------------------------------------------------------------
`define CFG_BASE_STRAP_LO   12'h3f0
`define CFG_BASE_STRAP_HI   12'h370
`define BASE_MIN            12'h100
`define KBD_DATA_ADDR       12'h060
`define KBD_CMD_ADDR        12'h064
`define GCFG_FULL_DECODE    6
`define GLOBAL_CFG_RST      8'h00
`define IRQ_SEL_RST         4'h0
`define IRQ_SEL_RST_FLOPPY  4'h6
`define DMA_SEL_RST_FLOPPY  3'h2
`define DMA_SEL_RST_PAR     3'h4
`define IRQ_SEL_MAX_DIRECT  4'hd
`define IRQ_SEL_IRQ15       4'he
`define IRQ_SMI_LEVEL       2
`define PAR_IRQ_PIN_MASK    16'h1cf8

// ----------------------------------------------------------------------
// Extended control register modes with the interrupt always on
// ----------------------------------------------------------------------
`define ECP_MODE_FIFO       3'b010
`define ECP_MODE_ECP        3'b011
`define ECP_MODE_TEST       3'b110

`endif

//--- src/irq_level_decode.v
// Turns a four-bit interrupt level select into a one-hot vector of IRQ
// levels. Purely combinational; the caller registers the result.
`include "irq_dma_route_map.vh"

module irq_level_decode (
  input  wire [3:0]  level_i,
  output reg  [15:0] pins_o
);

  always @* begin
    pins_o = 16'h0000;
    if (level_i == `IRQ_SEL_IRQ15) begin
      pins_o[15] = 1'b1;
    end else if (level_i != 4'h0 && level_i <= `IRQ_SEL_MAX_DIRECT) begin
      pins_o[level_i] = 1'b1;
    end
  end

endmodule

//--- src/base_decode.v
// Checks a relocatable I/O base for range and alignment and compares it
// with the bus address. Combinational; assumes a twelve-bit base.
`include "irq_dma_route_map.vh"

module base_decode #(
  parameter ALIGN_BITS = 3
) (
  input  wire [11:0] base_i,
  input  wire [15:0] addr_i,
  input  wire        full_decode_i,
  output wire        valid_o,
  output wire        hit_o
);

  localparam [11:0] LOW_MASK = (12'h001 << ALIGN_BITS) - 12'h001;
  localparam [11:0] BASE_MAX = ~LOW_MASK;

  assign valid_o = (base_i >= `BASE_MIN) && (base_i <= BASE_MAX) &&
                   ((base_i & LOW_MASK) == 12'h000);
  // Upper address bits only qualify when full decode is on.
  assign hit_o   = valid_o && (addr_i[11:ALIGN_BITS] == base_i[11:ALIGN_BITS]) &&
                   (!full_decode_i || addr_i[15:12] == 4'h0);

endmodule

//--- src/irq_dma_router.v
// Configuration port, I/O decode and IRQ/DMA routing for the logical
// devices of a multi-function I/O controller.
// Assumes ISA strobes already synchronous to CLK_I; pins are resolved
// outside from the value and output-enable pairs.
//
// Notes on behaviour
// [R1] Keyboard decodes at fixed base, data at +0, command/status at +4.
// [R2] Config index port at base, data port at base+1, even bases only.
// [R3] Config base after reset follows the strap; indices 0x26/0x27 move it.
// [R4] Bases decode on A11..A0; global bit six adds A15..A12 equal zero.
// [R5] Level select low nibble: zero none, 1..13 direct, 0x0E is IRQ15.
// [R6] Level select resets to zero, floppy to 0x06, on every reset.
// [R7] Routed interrupts are active high; management interrupt is active low.
// [R8] Interrupt needs non-zero level and block enable; floppy uses DOR D3.
// [R9] Parallel interrupt needs control D4 except in ECP modes 010,011,110; in ECP also service bit clear.
// [R10] Serial interrupt needs an interrupt enable bit 0..3 and aux output 2 set.
// [R11] IRQ pins selected by no device stay undriven.
// [R12] Software must disable the management interrupt before using level two.
// [R13] Serial mode carries every level; parallel pins only 3-7, 10-12.
// [R14] DMA select low three bits: 1..3 channel, others no channel.
// [R15] DMA select resets to 0x02 floppy, 0x04 parallel, on every reset.
// [R16] DMA active for select 1..3 with block enable, DOR D3 or ecr D3.
// [R17] DMA request pins selected by no device stay undriven.
// [R18] Block register disables drop interrupt and acknowledge besides activation.
// [R19] Floppy interrupt and acknowledge float when DMA enable off or powered down.
// [R20] ECP interrupt gated in modes 000,001,100,101,111; DMA by ecr enable.
// [R21] Device is on by activate or power bit; both bits are one flag.
`include "irq_dma_route_map.vh"

module irq_dma_router #(
  parameter NUM_DEV = 4
) (
  input  wire        CLK_I,
  input  wire        RESET_I,
  input  wire        SOFT_RESET_I,
  input  wire        CONFIG_PORT_STRAP_I,
  input  wire [15:0] SA_I,
  input  wire [7:0]  SD_I,
  input  wire        IOR_N_I,
  input  wire        IOW_N_I,
  output reg  [7:0]  SD_O,
  output reg         SD_OE_O,
  output reg         KBD_DATA_SEL_O,
  output reg         KBD_CMD_SEL_O,
  output reg  [3:0]  DEV_SEL_O,
  input  wire [3:0]  DEV_IRQ_REQ_I,
  input  wire        FLOPPY_DRQ_I,
  input  wire        PRINTER_DMA_REQUEST_I,
  input  wire        FLOPPY_DMA_IRQ_ENABLE_I,
  input  wire        FLOPPY_POWER_DOWN_I,
  input  wire        PRINTER_IRQ_ENABLE_I,
  input  wire        ECP_OPERATION_I,
  input  wire [2:0]  ECP_MODE_I,
  input  wire        ECP_SERVICE_INTERRUPT_I,
  input  wire        ECP_DMA_ENABLE_I,
  input  wire [7:0]  UART_INTERRUPT_ENABLE_REG_I,
  input  wire [1:0]  MODEM_AUX_OUTPUT_2_I,
  input  wire        SERIAL_IRQ_MODE_I,
  input  wire        SMI_REQ_I,
  output reg  [15:0] IRQ_O,
  output reg  [15:0] IRQ_OE_O,
  output reg         SYSTEM_MGMT_IRQ_N_O,
  output reg  [15:0] SERIAL_IRQ_LEVELS_O,
  output reg  [3:1]  DMA_REQUEST_PIN_O,
  output reg  [3:1]  DMA_REQUEST_PIN_OE_O,
  output reg  [1:0]  DACK_EN_O
);

  // ----------------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------------
  reg [7:0]  index_q;
  reg [7:0]  ldn_q;
  reg [7:0]  gcfg_q;
  reg [11:0] cfg_base_q;
  reg        strap_pend_q;
  reg        iow_n_prev_q;
  reg [3:0]  on_q;
  reg [11:0] dev_base_q [0:3];
  reg [3:0]  irq_sel_q  [0:3];
  reg [2:0]  dma_sel_q  [0:1];

  wire        full_decode = gcfg_q[`GCFG_FULL_DECODE];
  wire        wr_pulse    = !IOW_N_I && iow_n_prev_q;
  wire        io_cycle    = !IOW_N_I || !IOR_N_I;
  wire        cfg_hit;
  wire        idx_hit     = cfg_hit && !SA_I[0];
  wire        data_hit    = cfg_hit && SA_I[0];
  wire [3:0]  base_ok;
  wire [3:0]  base_hit;
  wire [63:0] lvl_pins_w;

  // Maps a logical device number to {known, slot}.
  function [2:0] slot_of;
    input [7:0] ldn;
    begin
      case (ldn)
        `LDN_FLOPPY:   slot_of = 3'b100;
        `LDN_PARALLEL: slot_of = 3'b101;
        `LDN_SERIAL1:  slot_of = 3'b110;
        `LDN_SERIAL2:  slot_of = 3'b111;
        default:       slot_of = 3'b000;
      endcase
    end
  endfunction

  wire [2:0] slot_w  = slot_of(ldn_q);
  wire       slot_ok = slot_w[2];
  wire [1:0] slot    = slot_w[1:0];

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // [R2] config index/data
  base_decode #(
    .ALIGN_BITS    (1)
  ) u_cfg_decode (
    .base_i        (cfg_base_q),
    .addr_i        (SA_I),
    .full_decode_i (full_decode),
    .valid_o       (),
    .hit_o         (cfg_hit)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_DEV; g = g + 1) begin : g_dev
      // [R4] per-device base decode
      base_decode #(
        .ALIGN_BITS    ((g == 1) ? 2 : 3)
      ) u_dev_decode (
        .base_i        (dev_base_q[g]),
        .addr_i        (SA_I),
        .full_decode_i (full_decode),
        .valid_o       (base_ok[g]),
        .hit_o         (base_hit[g])
      );
      // [R5] level select decode
      irq_level_decode u_level (
        .level_i (irq_sel_q[g]),
        .pins_o  (lvl_pins_w[g*16 +: 16])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Configuration writes
  // ----------------------------------------------------------------------
  integer i;
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      index_q      <= 8'h00;
      ldn_q        <= 8'h00;
      gcfg_q       <= `GLOBAL_CFG_RST;
      cfg_base_q   <= `CFG_BASE_STRAP_LO;
      strap_pend_q <= 1'b1;
      iow_n_prev_q <= 1'b1;
      on_q         <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        dev_base_q[i] <= 12'h000;
        irq_sel_q[i]  <= `IRQ_SEL_RST;
      end
      // [R6] level select reset
      irq_sel_q[0] <= `IRQ_SEL_RST_FLOPPY;
      // [R15] DMA select reset
      dma_sel_q[0] <= `DMA_SEL_RST_FLOPPY;
      dma_sel_q[1] <= `DMA_SEL_RST_PAR;
    end else begin
      iow_n_prev_q <= IOW_N_I;
      // [R3] strap caught once
      if (strap_pend_q) begin
        strap_pend_q <= 1'b0;
        cfg_base_q   <= CONFIG_PORT_STRAP_I ? `CFG_BASE_STRAP_HI : `CFG_BASE_STRAP_LO;
      end
      if (wr_pulse && idx_hit) begin
        index_q <= SD_I;
      end
      if (wr_pulse && data_hit) begin
        case (index_q)
          `IDX_LDN:        ldn_q <= SD_I;
          `IDX_GLOBAL_CFG: gcfg_q <= SD_I;
          // [R3] config base relocation
          `IDX_CFG_BASE_LO: cfg_base_q[7:0] <= {SD_I[7:1], 1'b0};
          `IDX_CFG_BASE_HI: cfg_base_q[11:8] <= SD_I[3:0];
          // [R21] linked power bits
          `IDX_POWER: begin
            on_q[0] <= SD_I[`PWR_BIT_FLOPPY];
            on_q[1] <= SD_I[`PWR_BIT_PARALLEL];
            on_q[2] <= SD_I[`PWR_BIT_SERIAL1];
            on_q[3] <= SD_I[`PWR_BIT_SERIAL2];
          end
          `IDX_ACTIVATE: if (slot_ok) begin
            on_q[slot] <= SD_I[0];
          end
          `IDX_BASE_HI: if (slot_ok) begin
            dev_base_q[slot][11:8] <= SD_I[3:0];
          end
          `IDX_BASE_LO: if (slot_ok) begin
            dev_base_q[slot][7:0] <= SD_I;
          end
          `IDX_IRQ_SEL: if (slot_ok) begin
            irq_sel_q[slot] <= SD_I[3:0];
          end
          // [R14] DMA select field
          `IDX_DMA_SEL: if (slot_ok && !slot[1]) begin
            dma_sel_q[slot[0]] <= SD_I[2:0];
          end
          default: ;
        endcase
      end
      // Soft reset returns the routing selects to their defaults.
      if (SOFT_RESET_I) begin
        for (i = 0; i < 4; i = i + 1) begin
          irq_sel_q[i] <= `IRQ_SEL_RST;
        end
        // [R6] soft reset defaults
        irq_sel_q[0] <= `IRQ_SEL_RST_FLOPPY;
        // [R15] soft reset defaults
        dma_sel_q[0] <= `DMA_SEL_RST_FLOPPY;
        dma_sel_q[1] <= `DMA_SEL_RST_PAR;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration reads
  // ----------------------------------------------------------------------
  reg [7:0] rd_d;
  reg [7:0] pwr_rd;
  always @* begin
    pwr_rd = 8'h00;
    pwr_rd[`PWR_BIT_FLOPPY]   = on_q[0];
    pwr_rd[`PWR_BIT_PARALLEL] = on_q[1];
    pwr_rd[`PWR_BIT_SERIAL1]  = on_q[2];
    pwr_rd[`PWR_BIT_SERIAL2]  = on_q[3];
    rd_d = 8'h00;
    if (idx_hit) begin
      rd_d = index_q;
    end else begin
      case (index_q)
        `IDX_LDN:         rd_d = ldn_q;
        `IDX_POWER:       rd_d = pwr_rd;
        `IDX_GLOBAL_CFG:  rd_d = gcfg_q;
        `IDX_CFG_BASE_LO: rd_d = cfg_base_q[7:0];
        `IDX_CFG_BASE_HI: rd_d = {4'h0, cfg_base_q[11:8]};
        `IDX_ACTIVATE:    rd_d = slot_ok ? {7'h00, on_q[slot]} : 8'h00;
        `IDX_BASE_HI:     rd_d = slot_ok ? {4'h0, dev_base_q[slot][11:8]} : 8'h00;
        `IDX_BASE_LO:     rd_d = slot_ok ? dev_base_q[slot][7:0] : 8'h00;
        `IDX_IRQ_SEL:     rd_d = slot_ok ? {4'h0, irq_sel_q[slot]} : 8'h00;
        `IDX_DMA_SEL: begin
          rd_d = (slot_ok && !slot[1]) ? {5'h00, dma_sel_q[slot[0]]} : 8'h00;
        end
        default:          rd_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt and DMA gating
  // ----------------------------------------------------------------------
  reg  [3:0]  dev_live;
  reg  [3:0]  irq_gate;
  reg  [3:0]  irq_act;
  reg  [1:0]  dma_act;
  reg         ecp_irq_on;
  reg  [15:0] lvl_drive;
  reg  [15:0] lvl_value;
  reg  [3:1]  drq_drive;
  reg  [3:1]  drq_value;
  reg  [2:0]  ch;
  wire [1:0]  dma_req = {PRINTER_DMA_REQUEST_I, FLOPPY_DRQ_I};

  integer s;
  integer k;
  always @* begin
    // [R18] live only with activation and valid base
    dev_live = on_q & base_ok;
    // [R20] modes with interrupt always on
    ecp_irq_on = (ECP_MODE_I == `ECP_MODE_FIFO) || (ECP_MODE_I == `ECP_MODE_ECP) ||
                 (ECP_MODE_I == `ECP_MODE_TEST);
    // [R19] floppy enable and power down
    irq_gate[0] = FLOPPY_DMA_IRQ_ENABLE_I && !FLOPPY_POWER_DOWN_I;
    // [R9] parallel enable and service bit
    irq_gate[1] = ECP_OPERATION_I ?
                  ((ecp_irq_on || PRINTER_IRQ_ENABLE_I) && !ECP_SERVICE_INTERRUPT_I) :
                  PRINTER_IRQ_ENABLE_I;
    // [R10] serial enables and aux output
    irq_gate[2] = (|UART_INTERRUPT_ENABLE_REG_I[3:0]) && MODEM_AUX_OUTPUT_2_I[0];
    irq_gate[3] = (|UART_INTERRUPT_ENABLE_REG_I[7:4]) && MODEM_AUX_OUTPUT_2_I[1];
    // [R8] non-zero level and block enable
    irq_act = dev_live & irq_gate;
    lvl_drive = 16'h0000;
    lvl_value = 16'h0000;
    for (s = 0; s < 4; s = s + 1) begin
      for (k = 0; k < 16; k = k + 1) begin
        if (irq_act[s] && lvl_pins_w[s*16+k]) begin
          lvl_drive[k] = 1'b1;
          lvl_value[k] = lvl_value[k] | DEV_IRQ_REQ_I[s];
        end
      end
    end
    // [R16] select one to three and enable
    dma_act[0] = dev_live[0] && dma_sel_q[0] != 3'h0 && dma_sel_q[0] <= 3'h3 &&
                 FLOPPY_DMA_IRQ_ENABLE_I && !FLOPPY_POWER_DOWN_I;
    // [R20] parallel DMA by ecr enable
    dma_act[1] = dev_live[1] && dma_sel_q[1] != 3'h0 && dma_sel_q[1] <= 3'h3 &&
                 ECP_OPERATION_I && ECP_DMA_ENABLE_I;
    drq_drive = 3'b000;
    drq_value = 3'b000;
    for (s = 0; s < 2; s = s + 1) begin
      for (k = 1; k < 4; k = k + 1) begin
        ch = k[2:0];
        if (dma_act[s] && dma_sel_q[s] == ch) begin
          drq_drive[k] = 1'b1;
          drq_value[k] = drq_value[k] | dma_req[s];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      SD_O                 <= 8'h00;
      SD_OE_O              <= 1'b0;
      KBD_DATA_SEL_O       <= 1'b0;
      KBD_CMD_SEL_O        <= 1'b0;
      DEV_SEL_O            <= 4'h0;
      IRQ_O                <= 16'h0000;
      IRQ_OE_O             <= 16'h0000;
      SYSTEM_MGMT_IRQ_N_O  <= 1'b1;
      SERIAL_IRQ_LEVELS_O  <= 16'h0000;
      DMA_REQUEST_PIN_O    <= 3'b000;
      DMA_REQUEST_PIN_OE_O <= 3'b000;
      DACK_EN_O            <= 2'b00;
    end else begin
      SD_O    <= rd_d;
      SD_OE_O <= !IOR_N_I && cfg_hit;
      // [R1] fixed keyboard addresses
      KBD_DATA_SEL_O <= io_cycle && SA_I[11:0] == `KBD_DATA_ADDR &&
                        (!full_decode || SA_I[15:12] == 4'h0);
      KBD_CMD_SEL_O  <= io_cycle && SA_I[11:0] == `KBD_CMD_ADDR &&
                        (!full_decode || SA_I[15:12] == 4'h0);
      DEV_SEL_O <= io_cycle ? (base_hit & on_q) : 4'h0;
      // [R13] serial frame carries every level
      SERIAL_IRQ_LEVELS_O <= SERIAL_IRQ_MODE_I ? (lvl_value & lvl_drive) : 16'h0000;
      // [R7] active-high routed levels
      IRQ_O <= lvl_value;
      // [R11] unselected pins undriven
      IRQ_OE_O <= SERIAL_IRQ_MODE_I ? 16'h0000 : (lvl_drive & `PAR_IRQ_PIN_MASK);
      // [R7] management interrupt active low
      SYSTEM_MGMT_IRQ_N_O <= !(SMI_REQ_I || lvl_value[`IRQ_SMI_LEVEL]);
      DMA_REQUEST_PIN_O <= drq_value;
      // [R17] unselected DMA pins undriven
      DMA_REQUEST_PIN_OE_O <= drq_drive;
      // [R18] acknowledge follows DMA gating
      DACK_EN_O <= dma_act;
    end
  end

endmodule

//--- verif/irq_dma_router_asserts.sv
// Port-level checks for the interrupt and DMA routing block.
// Assumes one clock domain and a synchronous active-high reset.
module irq_dma_router_asserts (
  input wire        CLK_I,
  input wire        RESET_I,
  input wire [15:0] SA_I,
  input wire        IOR_N_I,
  input wire        SERIAL_IRQ_MODE_I,
  input wire        SMI_REQ_I,
  input wire        FLOPPY_DMA_IRQ_ENABLE_I,
  input wire        FLOPPY_POWER_DOWN_I,
  input wire        ECP_DMA_ENABLE_I,
  input wire        SD_OE_O,
  input wire        KBD_DATA_SEL_O,
  input wire        KBD_CMD_SEL_O,
  input wire [15:0] IRQ_OE_O,
  input wire        SYSTEM_MGMT_IRQ_N_O,
  input wire [15:0] SERIAL_IRQ_LEVELS_O,
  input wire [3:1]  DMA_REQUEST_PIN_OE_O,
  input wire [1:0]  DACK_EN_O
);
  logic rst_q;

  // The edge after reset release still shows reset values, so it is skipped.
  always @(posedge CLK_I) begin
    rst_q <= RESET_I;
  end

  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I || rst_q);

  property p_kbd_data;
    (!IOR_N_I && SA_I == 16'h0060) ##1 (!IOR_N_I && SA_I == 16'h0060) |-> KBD_DATA_SEL_O;
  endproperty
  property p_kbd_cmd;
    $fell(IOR_N_I) && SA_I == 16'h0064 |=> KBD_CMD_SEL_O;
  endproperty
  property p_pin_mask;
    (IRQ_OE_O & 16'he307) == 16'h0000;
  endproperty
  property p_serial_oe;
    SERIAL_IRQ_MODE_I |=> IRQ_OE_O == 16'h0000;
  endproperty
  property p_par_levels;
    !SERIAL_IRQ_MODE_I |=> SERIAL_IRQ_LEVELS_O == 16'h0000;
  endproperty
  property p_smi;
    SMI_REQ_I [*2] |-> !SYSTEM_MGMT_IRQ_N_O;
  endproperty
  property p_no_dma;
    !FLOPPY_DMA_IRQ_ENABLE_I && !ECP_DMA_ENABLE_I |=> DMA_REQUEST_PIN_OE_O == 3'h0 && DACK_EN_O == 2'h0;
  endproperty
  property p_floppy_pd;
    FLOPPY_POWER_DOWN_I |=> !DACK_EN_O[0];
  endproperty
  property p_rd_idle;
    IOR_N_I |=> !SD_OE_O;
  endproperty

  a_kbd_data: assert property (p_kbd_data) else $error("keyboard data select missing");
  a_kbd_cmd: assert property (p_kbd_cmd) else $error("keyboard command select missing");
  a_pin_mask: assert property (p_pin_mask) else $error("unavailable IRQ pin driven");
  a_serial_oe: assert property (p_serial_oe) else $error("pin driven in serial mode");
  a_par_levels: assert property (p_par_levels) else $error("serial levels in pin mode");
  a_smi: assert property (p_smi) else $error("management interrupt not low");
  a_no_dma: assert property (p_no_dma) else $error("DMA active without enable");
  a_floppy_pd: assert property (p_floppy_pd) else $error("floppy acknowledge while down");
  a_rd_idle: assert property (p_rd_idle) else $error("read data driven when idle");

  c_read: cover property (SD_OE_O);
  c_floppy_dack: cover property (DACK_EN_O[0]);
  c_smi: cover property (!SYSTEM_MGMT_IRQ_N_O);
endmodule

bind irq_dma_router irq_dma_router_asserts u_chk (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .SA_I(SA_I), .IOR_N_I(IOR_N_I),
  .SERIAL_IRQ_MODE_I(SERIAL_IRQ_MODE_I), .SMI_REQ_I(SMI_REQ_I),
  .FLOPPY_DMA_IRQ_ENABLE_I(FLOPPY_DMA_IRQ_ENABLE_I),
  .FLOPPY_POWER_DOWN_I(FLOPPY_POWER_DOWN_I), .ECP_DMA_ENABLE_I(ECP_DMA_ENABLE_I),
  .SD_OE_O(SD_OE_O), .KBD_DATA_SEL_O(KBD_DATA_SEL_O), .KBD_CMD_SEL_O(KBD_CMD_SEL_O),
  .IRQ_OE_O(IRQ_OE_O), .SYSTEM_MGMT_IRQ_N_O(SYSTEM_MGMT_IRQ_N_O),
  .SERIAL_IRQ_LEVELS_O(SERIAL_IRQ_LEVELS_O), .DMA_REQUEST_PIN_OE_O(DMA_REQUEST_PIN_OE_O),
  .DACK_EN_O(DACK_EN_O));

//--- verif/irq_host_model.sv
// Host-side interrupt and DMA controller inputs seen through the pins.
// Assumes value and enable pairs; an undriven line toggles every cycle.
module irq_host_model (
  input  wire         clk_i,
  input  wire  [15:0] irq_i,
  input  wire  [15:0] irq_oe_i,
  input  wire  [3:1]  drq_i,
  input  wire  [3:1]  drq_oe_i,
  output logic [15:0] irq_line_o,
  output logic [3:1]  drq_line_o
);
  logic flip_q = 1'b0;

  always @(posedge clk_i) begin
    flip_q <= ~flip_q;
  end

  assign irq_line_o = (irq_i & irq_oe_i) | (~irq_oe_i & {16{flip_q}});
  assign drq_line_o = (drq_i & drq_oe_i) | (~drq_oe_i & {3{flip_q}});
endmodule

//--- verif/irq_dma_router_bench.sv
// Self-checking bench for the routing block, driving the config port.
// Assumes inputs change on the falling clock edge.
module irq_dma_router_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, srst = 1'b0, strap = 1'b0;
  logic        ior_n = 1'b1, iow_n = 1'b1, fdrq = 1'b0, pdrq = 1'b0, fen = 1'b0;
  logic        fpd = 1'b0, pen = 1'b0, ecp = 1'b0, svc = 1'b0, edma = 1'b0;
  logic        smode = 1'b0, smi = 1'b0;
  logic [15:0] sa = 16'h0000, cb = 16'h03f0, e;
  logic [7:0]  sd = 8'h00, uart_interrupt_enable_reg = 8'h00, sd_o;
  logic [3:0]  dev_req = 4'h0, dev_sel;
  logic [2:0]  mode = 3'h0;
  logic [1:0]  modem_aux_output_2 = 2'h0, dack;
  logic        sd_oe, kbd_d, kbd_c, smi_n;
  logic [15:0] irq, irq_oe, slev, irq_line;
  logic [3:1]  drq, drq_oe, drq_line;
  int          error_cnt = 0, tests_run = 0, cycles = 0;

  always #5 clk = ~clk;

  irq_dma_router dut (.CLK_I(clk), .RESET_I(rst), .SOFT_RESET_I(srst),
    .CONFIG_PORT_STRAP_I(strap), .SA_I(sa), .SD_I(sd), .IOR_N_I(ior_n), .IOW_N_I(iow_n),
    .SD_O(sd_o), .SD_OE_O(sd_oe), .KBD_DATA_SEL_O(kbd_d), .KBD_CMD_SEL_O(kbd_c),
    .DEV_SEL_O(dev_sel), .DEV_IRQ_REQ_I(dev_req), .FLOPPY_DRQ_I(fdrq),
    .PRINTER_DMA_REQUEST_I(pdrq), .FLOPPY_DMA_IRQ_ENABLE_I(fen), .FLOPPY_POWER_DOWN_I(fpd),
    .PRINTER_IRQ_ENABLE_I(pen), .ECP_OPERATION_I(ecp), .ECP_MODE_I(mode),
    .ECP_SERVICE_INTERRUPT_I(svc), .ECP_DMA_ENABLE_I(edma), .UART_INTERRUPT_ENABLE_REG_I(uart_interrupt_enable_reg),
    .MODEM_AUX_OUTPUT_2_I(modem_aux_output_2), .SERIAL_IRQ_MODE_I(smode), .SMI_REQ_I(smi), .IRQ_O(irq),
    .IRQ_OE_O(irq_oe), .SYSTEM_MGMT_IRQ_N_O(smi_n), .SERIAL_IRQ_LEVELS_O(slev),
    .DMA_REQUEST_PIN_O(drq), .DMA_REQUEST_PIN_OE_O(drq_oe), .DACK_EN_O(dack));

  irq_host_model host (.clk_i(clk), .irq_i(irq), .irq_oe_i(irq_oe), .drq_i(drq),
    .drq_oe_i(drq_oe), .irq_line_o(irq_line), .drq_line_o(drq_line));

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("ERROR %0t: timeout", $time);
      end_of_test;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    sa = a;
    sd = d;
    iow_n = 1'b0;
    tick(1);
    iow_n = 1'b1;
    tick(2);
  endtask
  task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
    io_wr(cb, idx);
    io_wr(cb + 16'h0001, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    sa = a;
    ior_n = 1'b0;
    tick(2);
    chk(sd_oe ? {7'h00, sd_oe, sd_o} : 16'h0000, {7'h00, exp[8:0]});
    chk({kbd_d, kbd_c}, exp[15:14]);
    ior_n = 1'b1;
    tick(2);
  endtask
  task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
    io_wr(cb, idx);
    rd(cb + 16'h0001, {8'h01, exp});
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask

  initial begin
    tick(2);
    rst = 1'b0;
    tick(2);
    cfg_rd(8'h70, 8'h06);
    cfg_rd(8'h74, 8'h02);
    cfg(8'h07, 8'h03);
    cfg_rd(8'h70, 8'h00);
    cfg_rd(8'h74, 8'h04);
    cfg_rd(8'h71, 8'h00);
    done("reset values");
    rd(16'h0060, 16'h8000);
    rd(16'h0064, 16'h4000);
    rd(16'h1060, 16'h8000);
    cfg(8'h24, 8'h40);
    rd(16'h1060, 16'h0000);
    rd(16'h0060, 16'h8000);
    cfg(8'h24, 8'h00);
    done("keyboard decode");
    cfg(8'h07, 8'h00);
    cfg(8'h60, 8'h02);
    cfg(8'h61, 8'h00);
    cfg(8'h30, 8'h01);
    dev_req = 4'h1;
    fen = 1'b1;
    // Management interrupt goes low while level two is assigned.
    for (int v = 0; v < 16; v++) begin
      cfg(8'h70, v[7:0]);
      e = (v >= 1 && v <= 13) ? 16'h0001 << v : (v == 14 ? 16'h8000 : 16'h0000);
      chk(irq_oe, e & 16'h1cf8);
      chk(irq_line & irq_oe, e & 16'h1cf8);
      chk(smi_n, v != 2);
      smode = 1'b1;
      tick(2);
      chk(slev, e);
      chk(irq_oe, 16'h0000);
      smode = 1'b0;
    end
    cfg(8'h70, 8'h06);
    fen = 1'b0;
    tick(2);
    chk(irq_oe, 16'h0000);
    fen = 1'b1;
    fpd = 1'b1;
    tick(2);
    chk(irq_oe, 16'h0000);
    fpd = 1'b0;
    cfg(8'h30, 8'h00);
    chk(irq_oe, 16'h0000);
    cfg(8'h22, 8'h01);
    chk(irq_oe, 16'h0040);
    cfg_rd(8'h30, 8'h01);
    done("floppy interrupt");
    fdrq = 1'b1;
    for (int v = 0; v < 8; v++) begin
      cfg(8'h74, v[7:0]);
      e = (v >= 1 && v <= 3) ? 16'h0001 << v : 16'h0000;
      chk({drq_line & drq_oe, 1'b0}, e);
      chk(dack[0], e != 16'h0000);
    end
    done("floppy DMA");
    cfg(8'h07, 8'h03);
    cfg(8'h60, 8'h02);
    cfg(8'h61, 8'h78);
    cfg(8'h30, 8'h01);
    cfg(8'h70, 8'h07);
    cfg(8'h74, 8'h03);
    dev_req = 4'h2;
    ecp = 1'b1;
    pdrq = 1'b1;
    for (int m = 0; m < 8; m++) begin
      mode = m[2:0];
      tick(2);
      chk(irq_oe[7], m == 2 || m == 3 || m == 6);
    end
    pen = 1'b1;
    tick(2);
    chk(irq_oe[7], 1'b1);
    svc = 1'b1;
    tick(2);
    chk(irq_oe[7], 1'b0);
    edma = 1'b1;
    tick(2);
    chk({drq_line & drq_oe, dack[1]}, 4'h9);
    edma = 1'b0;
    tick(2);
    chk({drq_oe, dack[1]}, 4'h0);
    done("parallel port");
    cfg(8'h07, 8'h04);
    cfg(8'h60, 8'h03);
    cfg(8'h61, 8'hf8);
    cfg(8'h30, 8'h01);
    cfg(8'h70, 8'h04);
    dev_req = 4'h4;
    chk(irq_oe[4], 1'b0);
    uart_interrupt_enable_reg = 8'h08;
    tick(2);
    chk(irq_oe[4], 1'b0);
    modem_aux_output_2 = 2'h1;
    tick(2);
    chk(irq_line[4] & irq_oe[4], 1'b1);
    smi = 1'b1;
    tick(2);
    chk(smi_n, 1'b0);
    smi = 1'b0;
    sa = 16'h03fa;
    ior_n = 1'b0;
    tick(2);
    chk(smi_n, 1'b1);
    chk(dev_sel, 4'h4);
    ior_n = 1'b1;
    tick(2);
    done("serial port");
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    tick(1);
    cfg_rd(8'h70, 8'h00);
    cfg(8'h07, 8'h03);
    cfg_rd(8'h74, 8'h04);
    done("soft reset");
    cfg(8'h26, 8'h61);
    cb = 16'h0360;
    cfg_rd(8'h07, 8'h03);
    rst = 1'b1;
    strap = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
    cb = 16'h0370;
    cfg_rd(8'h07, 8'h00);
    done("config port");
    end_of_test;
  end
endmodule
